// file: rtl/tmcs_map.svh
`ifndef TMCS_MAP_SVH
`define TMCS_MAP_SVH

// command codes
`define TMCS_CMD_READ_TEMP   8'haa
`define TMCS_CMD_START_CONV  8'hee
`define TMCS_CMD_STOP_CONV   8'h22
`define TMCS_CMD_MEM_ACCESS  8'h17
`define TMCS_CMD_CFG_ACCESS  8'hac

// conversion_config_status layout
`define TMCS_CFG_DONE_BIT    7
`define TMCS_CFG_MODE_BIT    0
`define TMCS_CFG_FIXED_BITS  6'h25
`define TMCS_CFG_MODE_RST    1'h0
`define TMCS_CFG_DONE_RST    1'h1

// bus address upper nibble, lower three bits come from the address pins
`define TMCS_DEV_ADDR_HI     4'h5
`define TMCS_IDLE_BYTE       8'hff
`define TMCS_TEMP_RST        16'h0000

// conversion time
`define TMCS_CLK_MHZ         20
`define TMCS_CONV_TIME_US    1000

`endif

// file: rtl/tmcs_pkg.sv
package tmcs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RXB,
        ST_RACK,
        ST_TXB,
        ST_TACK
    } tmcs_bus_st_t;

    typedef enum logic [1:0] {
        KD_ADDR,
        KD_CMD,
        KD_MADDR,
        KD_DATA
    } tmcs_kind_t;

    typedef struct packed {
        tmcs_bus_st_t st;
        tmcs_kind_t   kind;
        logic [3:0]   bit_cnt;
        logic [7:0]   shreg;
        logic         rw;
        logic [7:0]   cmd;
        logic [7:0]   ptr;
        logic [1:0]   dcnt;
        logic [7:0]   lsb_hold;
        logic         scl_d;
        logic         sda_oe;
        logic         sda_lvl;
        logic         busy;
        logic         run;
        logic         done;
        logic         mode;
        logic [23:0]  conv_cnt;
        logic [15:0]  temp;
    } tmcs_state_t;

endpackage

// file: rtl/tmcs_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tmcs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tmcs_sync_t;

    tmcs_sync_t r_ff;
    tmcs_sync_t nxt_r;

    // first stage feeds only the second
    always_comb begin
        nxt_r    = r_ff;
        nxt_r.s1 = async_in;
        nxt_r.s2 = r_ff.s1;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r_ff <= '1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sync_out = r_ff.s2;
endmodule

`default_nettype wire

// file: rtl/tmcs_eeprom.sv
`timescale 1ns/1ps
`default_nettype none

module tmcs_eeprom (
    input  wire logic       clk_in,
    input  wire logic       we_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out
);
    // 256 bytes, 00..ff; write timing not modelled
    logic [7:0] mem [0:255];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    assign rdata_out = mem[addr_in];
endmodule

`default_nettype wire

// file: rtl/tmcs_top.sv
// Contract
// - Read-temperature returns the latest finished result as the following read bytes.
// - Start-conversion begins a conversion with no data, and repeats it in continuous mode.
// - With the mode bit at one, start-conversion does exactly one conversion, then idles.
// - With the mode bit at zero, conversions run on and each result overwrites the last.
// - Stop-conversion lets the running conversion finish, then idles until the next start.
// - Memory-access takes a start address, then reads or writes per the bus direction bit.
// - The user memory holds 256 bytes at addresses 00 to ff.
// - Config-access in write direction stores bit 0 of the next received byte as the config mode bit.
// - Config-access in read direction sends the config contents as the next byte.
// - The top config bit reads one when conversion is done and zero while one runs.
// - The lowest config bit is the mode bit, user read/write, shipped at zero.
// - Memory accesses never change the thermometer or config contents.
`include "tmcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tmcs_top #(
    parameter int unsigned CONV_CYCLES = `TMCS_CONV_TIME_US * `TMCS_CLK_MHZ
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic [2:0]  addr_pin_in,
    input  wire logic [15:0] temp_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    output logic             conv_busy_out
);
    import tmcs_pkg::*;

    localparam logic [23:0] CONV_LAST = 24'(CONV_CYCLES - 1);

    tmcs_state_t r_ff;
    tmcs_state_t nxt_r;

    logic [20:0] sync_vec;
    logic        scl_s;
    logic        sda_s;
    logic [2:0]  addr_s;
    logic [15:0] temp_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        mem_we;
    logic [7:0]  mem_rdata;
    logic        load_tx;
    logic [7:0]  tx_byte;
    logic        start_req;
    logic        stop_req;
    logic        cfg_wr;
    logic        conv_fin;

    function automatic logic [7:0] cfg_byte(input logic done, input logic mode);
        cfg_byte = {done, `TMCS_CFG_FIXED_BITS, mode};
    endfunction

    tmcs_sync #(
        .W(21)
    ) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({scl_in, sda_in, addr_pin_in, temp_in}),
        .sync_out   (sync_vec)
    );

    assign {scl_s, sda_s, addr_s, temp_s} = sync_vec;

    // memory sits beside the thermometer state, never touches it
    tmcs_eeprom u_mem (
        .clk_in    (clk_in),
        .we_in     (mem_we),
        .addr_in   (r_ff.ptr),
        .wdata_in  (r_ff.shreg),
        .rdata_out (mem_rdata)
    );

    // sda delayed one cycle; start and stop are sda edges seen while scl is high
    logic sda_d_ff;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sda_d_ff <= 1'h1;
        end else begin
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~r_ff.scl_d;
    assign scl_fall   = ~scl_s & r_ff.scl_d;
    assign start_cond = scl_s & r_ff.scl_d & sda_d_ff & ~sda_s;
    assign stop_cond  = scl_s & r_ff.scl_d & ~sda_d_ff & sda_s;

    // byte handed to the master for the current command
    always_comb begin
        tx_byte = `TMCS_IDLE_BYTE;
        if (r_ff.cmd == `TMCS_CMD_READ_TEMP) begin
            if (r_ff.dcnt == 2'h0) begin
                tx_byte = r_ff.temp[15:8];
            end else if (r_ff.dcnt == 2'h1) begin
                tx_byte = r_ff.lsb_hold;
            end
        end else if (r_ff.cmd == `TMCS_CMD_CFG_ACCESS) begin
            tx_byte = cfg_byte(r_ff.done, r_ff.mode);
        end else if (r_ff.cmd == `TMCS_CMD_MEM_ACCESS) begin
            tx_byte = mem_rdata;
        end
    end

    always_comb begin
        nxt_r       = r_ff;
        nxt_r.scl_d = scl_s;
        mem_we      = 1'h0;
        load_tx     = 1'h0;
        start_req   = 1'h0;
        stop_req    = 1'h0;
        cfg_wr      = 1'h0;
        conv_fin    = 1'h0;

        if (start_cond) begin
            // repeated start keeps cmd and pointer for a read phase
            nxt_r.st      = ST_RXB;
            nxt_r.kind    = KD_ADDR;
            nxt_r.bit_cnt = 4'h0;
            nxt_r.sda_oe  = 1'h0;
        end else if (stop_cond) begin
            nxt_r.st     = ST_IDLE;
            nxt_r.sda_oe = 1'h0;
        end else begin
            case (r_ff.st)
                ST_RXB: begin
                    if (scl_rise) begin
                        nxt_r.shreg   = {r_ff.shreg[6:0], sda_s};
                        nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
                    end else if (scl_fall && r_ff.bit_cnt == 4'h8) begin
                        nxt_r.st     = ST_RACK;
                        nxt_r.sda_oe = 1'h1;
                        case (r_ff.kind)
                            KD_ADDR: begin
                                if (r_ff.shreg[7:1] == {`TMCS_DEV_ADDR_HI, addr_s}) begin
                                    nxt_r.rw   = r_ff.shreg[0];
                                    nxt_r.kind = KD_CMD;
                                    nxt_r.dcnt = 2'h0;
                                end else begin
                                    nxt_r.st     = ST_IDLE;
                                    nxt_r.sda_oe = 1'h0;
                                end
                            end
                            KD_CMD: begin
                                nxt_r.cmd  = r_ff.shreg;
                                nxt_r.dcnt = 2'h0;
                                nxt_r.kind = KD_DATA;
                                if (r_ff.shreg == `TMCS_CMD_MEM_ACCESS) begin
                                    nxt_r.kind = KD_MADDR;
                                end
                                start_req = (r_ff.shreg == `TMCS_CMD_START_CONV);
                                stop_req  = (r_ff.shreg == `TMCS_CMD_STOP_CONV);
                            end
                            KD_MADDR: begin
                                nxt_r.ptr  = r_ff.shreg;
                                nxt_r.kind = KD_DATA;
                            end
                            default: begin
                                if (r_ff.cmd == `TMCS_CMD_CFG_ACCESS && r_ff.dcnt == 2'h0) begin
                                    cfg_wr = 1'h1;
                                end
                                if (r_ff.cmd == `TMCS_CMD_MEM_ACCESS) begin
                                    mem_we    = 1'h1;
                                    nxt_r.ptr = r_ff.ptr + 8'h01;
                                end
                                if (r_ff.dcnt != 2'h3) begin
                                    nxt_r.dcnt = r_ff.dcnt + 2'h1;
                                end
                            end
                        endcase
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        nxt_r.sda_oe  = 1'h0;
                        nxt_r.bit_cnt = 4'h0;
                        nxt_r.st      = ST_RXB;
                        load_tx       = r_ff.rw;
                    end
                end
                ST_TXB: begin
                    if (scl_fall) begin
                        if (r_ff.bit_cnt == 4'h7) begin
                            nxt_r.sda_oe = 1'h0;
                            nxt_r.st     = ST_TACK;
                        end else begin
                            nxt_r.shreg   = {r_ff.shreg[6:0], 1'h0};
                            nxt_r.sda_oe  = ~r_ff.shreg[6];
                            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise && sda_s) begin
                        // nack: master is done, wait for stop
                        nxt_r.st = ST_IDLE;
                    end else if (scl_fall) begin
                        nxt_r.bit_cnt = 4'h0;
                        load_tx       = 1'h1;
                    end
                end
                default: begin
                    nxt_r.sda_oe = 1'h0;
                end
            endcase
        end

        if (load_tx) begin
            nxt_r.st     = ST_TXB;
            nxt_r.shreg  = tx_byte;
            nxt_r.sda_oe = ~tx_byte[7];
            if (r_ff.cmd == `TMCS_CMD_READ_TEMP && r_ff.dcnt == 2'h0) begin
                // snapshot low byte so a finishing conversion cannot tear the pair
                nxt_r.lsb_hold = r_ff.temp[7:0];
            end
            if (r_ff.cmd == `TMCS_CMD_MEM_ACCESS) begin
                nxt_r.ptr = r_ff.ptr + 8'h01;
            end
            if (r_ff.dcnt != 2'h3) begin
                nxt_r.dcnt = r_ff.dcnt + 2'h1;
            end
        end

        if (cfg_wr) begin
            nxt_r.mode = r_ff.shreg[`TMCS_CFG_MODE_BIT];
        end

        // conversion engine
        if (r_ff.busy) begin
            if (r_ff.conv_cnt == CONV_LAST) begin
                conv_fin       = 1'h1;
                nxt_r.busy     = 1'h0;
                nxt_r.done     = 1'h1;
                nxt_r.temp     = temp_s;
                nxt_r.conv_cnt = 24'h00_0000;
            end else begin
                nxt_r.conv_cnt = r_ff.conv_cnt + 24'h00_0001;
            end
        end else if (r_ff.run) begin
            // one idle cycle between results lets done show each completion
            nxt_r.busy = 1'h1;
            nxt_r.done = 1'h0;
        end

        if (start_req) begin
            nxt_r.run = ~r_ff.mode;
            if (!r_ff.busy) begin
                nxt_r.busy     = 1'h1;
                nxt_r.done     = 1'h0;
                nxt_r.conv_cnt = 24'h00_0000;
            end
        end else if (stop_req) begin
            nxt_r.run = 1'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r_ff          <= '0;
            r_ff.st       <= ST_IDLE;
            r_ff.kind     <= KD_ADDR;
            r_ff.scl_d    <= 1'h1;
            r_ff.cmd      <= `TMCS_IDLE_BYTE;
            r_ff.done     <= `TMCS_CFG_DONE_RST;
            r_ff.mode     <= `TMCS_CFG_MODE_RST;
            r_ff.temp     <= `TMCS_TEMP_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sda_out       = r_ff.sda_lvl;
    assign sda_oe_out    = r_ff.sda_oe;
    assign conv_busy_out = r_ff.busy;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_start_begins_conv: assert property (start_req && !r_ff.busy |=> r_ff.busy && !r_ff.done)
        else $error("start command did not begin a conversion");
    a_oneshot_goes_idle: assert property (conv_fin && !r_ff.run && !start_req
        |=> !r_ff.busy [*2])
        else $error("one-shot conversion did not stay idle");
    a_cont_restarts: assert property (conv_fin && r_ff.run && !stop_req && !start_req
        |=> ##1 r_ff.busy)
        else $error("continuous mode did not restart conversion");
    a_result_stored: assert property (conv_fin |=> r_ff.temp == $past(temp_s))
        else $error("finished result not stored");
    a_stop_lets_finish: assert property (stop_req && r_ff.busy && !conv_fin
        |=> r_ff.busy && !r_ff.run)
        else $error("stop aborted the running conversion");
    a_done_vs_busy: assert property (r_ff.busy |-> !r_ff.done)
        else $error("done flag set during conversion");
    a_cfg_write_mode: assert property (cfg_wr |=> r_ff.mode == $past(r_ff.shreg[0]))
        else $error("config write did not store mode bit");
    a_cfg_read_byte: assert property (load_tx && r_ff.cmd == `TMCS_CMD_CFG_ACCESS
        |=> r_ff.shreg == {$past(r_ff.done), 6'h25, $past(r_ff.mode)})
        else $error("config read byte wrong");
    a_temp_msb_sent: assert property (load_tx && r_ff.cmd == `TMCS_CMD_READ_TEMP
        && r_ff.dcnt == 2'h0 |=> r_ff.shreg == $past(r_ff.temp[15:8]))
        else $error("temperature high byte not sent");
    a_mem_isolated: assert property (mem_we && !r_ff.busy
        |=> $stable(r_ff.temp) && $stable(r_ff.mode))
        else $error("memory write touched thermometer state");
    a_mem_ptr_step: assert property (mem_we |=> r_ff.ptr == $past(r_ff.ptr) + 8'h01)
        else $error("memory pointer did not advance");
endmodule

`default_nettype wire

// file: verification/tmcs_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none

// two-wire bus master; scl rests high between frames, 400 ns per bit
module tmcs_i2c_master (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    // data moves only while scl is low; sampled late in the high phase
    // so the slave's synchroniser delay never eats into the setup time
    task automatic bit_xfer(input logic b, output logic r);
        #100 sda_oe_out = !b;
        #100 scl_out = 1'b1;
        #190 r = sda_in;
        #10 scl_out = 1'b0;
    endtask

    // also serves as repeated start
    task automatic start_cond();
        #100 sda_oe_out = 1'b0;
        #100 scl_out = 1'b1;
        #200 sda_oe_out = 1'b1;
        #200 scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        #100 sda_oe_out = 1'b1;
        #100 scl_out = 1'b1;
        #200 sda_oe_out = 1'b0;
        #200;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask

    // nack on the last byte ends the read, even after a single byte
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(last, r);
    endtask
endmodule

`default_nettype wire

// file: verification/thermometer_eeprom_command_set_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmcs_map.svh"

module thermometer_eeprom_command_set_tb;
    logic        clk_in     = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  pins       = 3'h3;
    logic [15:0] temp_in    = 16'h0000;
    logic        scl;
    logic        m_oe;
    logic        dut_sda;
    logic        dut_oe;
    logic        conv_busy;
    logic        sda_w;
    logic        ack;
    int          bad_count  = 0;
    int          checks     = 0;
    int          seed       = 39448;
    int          mode_m     = 0;
    logic [15:0] temp_m     = 16'h0000;
    logic [7:0]  mem_m [256];
    logic [7:0]  tx_q [$];
    logic [7:0]  rx_q [$];
    logic [7:0]  a;
    logic [7:0]  b;

    // pulled-up wire, low while either side pulls
    assign sda_w = (dut_oe ? dut_sda : 1'b1) & !m_oe;
    always #25 clk_in = ~clk_in;

    // short conversion keeps the run small but still outlasts a config read
    tmcs_top #(
        .CONV_CYCLES(2000)
    ) tmcs_top_inst (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .scl_in        (scl),
        .sda_in        (sda_w),
        .addr_pin_in   (pins),
        .temp_in       (temp_in),
        .sda_out       (dut_sda),
        .sda_oe_out    (dut_oe),
        .conv_busy_out (conv_busy)
    );

    tmcs_i2c_master tmcs_i2c_master_inst (
        .sda_in     (sda_w),
        .scl_out    (scl),
        .sda_oe_out (m_oe)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] d);
        tmcs_i2c_master_inst.write_byte(d, ack);
        chk("ack", 16'h0001, {15'h0000, ack});
    endtask

    // command, queued bytes, then n reads after a repeated start (n = 0: write only)
    task automatic frame(input logic [7:0] cmd, input int n);
        logic [7:0] d;
        @(posedge clk_in);
        #2;
        tmcs_i2c_master_inst.start_cond();
        send({`TMCS_DEV_ADDR_HI, pins, 1'b0});
        send(cmd);
        foreach (tx_q[i]) send(tx_q[i]);
        rx_q.delete();
        if (n > 0) begin
            tmcs_i2c_master_inst.start_cond();
            send({`TMCS_DEV_ADDR_HI, pins, 1'b1});
        end
        for (int i = 0; i < n; i++) begin
            tmcs_i2c_master_inst.read_byte(i == n - 1, d);
            rx_q.push_back(d);
        end
        tmcs_i2c_master_inst.stop_cond();
        tx_q.delete();
    endtask

    task automatic cfg_chk(input int done);
        frame(`TMCS_CMD_CFG_ACCESS, 1);
        chk("config", {8'h00, done[0], `TMCS_CFG_FIXED_BITS, mode_m[0]}, {8'h00, rx_q[0]});
    endtask

    task automatic temp_chk();
        frame(`TMCS_CMD_READ_TEMP, 2);
        chk("temp", temp_m, {rx_q[0], rx_q[1]});
    endtask

    task automatic drive_temp(input logic [15:0] v);
        @(posedge clk_in);
        #2 temp_in = v;
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (conv_busy !== lvl && n < 3000) begin
            @(posedge clk_in);
            #2 n++;
        end
        if (n >= 3000) begin
            bad_count++;
            $display("MISMATCH busy_wait expected %b seen %b", lvl, conv_busy);
            complete_run();
        end
    endtask

    // counts busy cycles over a window longer than the restart gap
    task automatic idle_chk();
        int hi;
        hi = 0;
        repeat (50) begin
            @(posedge clk_in);
            #2;
            if (conv_busy !== 1'b0) hi++;
        end
        chk("busy_idle", 16'h0000, hi[15:0]);
    endtask

    task automatic set_mode(input logic [7:0] v);
        tx_q.push_back(v);
        frame(`TMCS_CMD_CFG_ACCESS, 0);
        mode_m = v[0];
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        #2 sys_rst_in = 1'b0;
        repeat (10) @(posedge clk_in);
        cfg_chk(1);
        set_mode(8'hff);
        cfg_chk(1);
        drive_temp(16'($random(seed)));
        frame(`TMCS_CMD_START_CONV, 0);
        cfg_chk(0);
        wait_busy(1'b0);
        temp_m = temp_in;
        idle_chk();
        temp_chk();
        frame(`TMCS_CMD_READ_TEMP, 1);
        chk("temp_msb", {8'h00, temp_m[15:8]}, {8'h00, rx_q[0]});
        set_mode(8'h00);
        frame(`TMCS_CMD_START_CONV, 0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        drive_temp(16'($random(seed)));
        temp_m = temp_in;
        repeat (2) @(posedge clk_in);
        #2;
        chk("busy_restart", 16'h0001, {15'h0000, conv_busy});
        wait_busy(1'b0);
        temp_chk();
        drive_temp(16'($random(seed)));
        frame(`TMCS_CMD_STOP_CONV, 0);
        chk("busy_after_stop", 16'h0001, {15'h0000, conv_busy});
        wait_busy(1'b0);
        temp_m = temp_in;
        idle_chk();
        temp_chk();
        // burst across the top of the array checks the pointer wrap
        a = 8'hfe;
        tx_q.push_back(a);
        for (int i = 0; i < 3; i++) begin
            b = 8'($random(seed));
            tx_q.push_back(b);
            mem_m[a] = b;
            a++;
        end
        frame(`TMCS_CMD_MEM_ACCESS, 0);
        tx_q.push_back(8'hfe);
        frame(`TMCS_CMD_MEM_ACCESS, 3);
        a = 8'hfe;
        for (int i = 0; i < 3; i++) begin
            chk("mem_burst", {8'h00, mem_m[a]}, {8'h00, rx_q[i]});
            a++;
        end
        repeat (4) begin
            a = 8'($random(seed));
            b = 8'($random(seed));
            tx_q.push_back(a);
            tx_q.push_back(b);
            mem_m[a] = b;
            frame(`TMCS_CMD_MEM_ACCESS, 0);
            tx_q.push_back(a);
            frame(`TMCS_CMD_MEM_ACCESS, 1);
            chk("mem_rand", {8'h00, mem_m[a]}, {8'h00, rx_q[0]});
        end
        cfg_chk(1);
        temp_chk();
        // a foreign address must stay unanswered
        tmcs_i2c_master_inst.start_cond();
        tmcs_i2c_master_inst.write_byte({`TMCS_DEV_ADDR_HI, ~pins, 1'b0}, ack);
        tmcs_i2c_master_inst.stop_cond();
        chk("foreign_ack", 16'h0000, {15'h0000, ack});
        complete_run();
    end
endmodule

`default_nettype wire
